// ---- rtl/ipacmp_stage.sv ----
// The implementer's own choices: the register offsets and the APB slave port.
`default_nettype none
module ipacmp_stage import ipacmp_pkg::*; #(
   parameter int OFS_W = 8
) (
   // clock, reset, enable
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic      [31:0]       prdata,
   output logic                   pslverr,
   // header byte stream from previous stage
   input  wire logic              hdr_start,
   input  wire logic              hdr_valid,
   input  wire logic [7:0]        hdr_byte,
   input  wire logic              hdr_end,
   input  wire logic [OFS_W-1:0]  hdr_base,
   input  wire logic              ingress,
   // result towards next stage and rewriter
   output logic                   res_valid,
   output logic                   res_match,
   output logic                   res_flow_hit,
   output logic      [2:0]        res_next_sel,
   output logic      [OFS_W-1:0]  res_next_offset,
   output logic                   res_sum_zero,
   output logic                   res_sum_fixup,
   output logic      [OFS_W-1:0]  res_sum_pos,
   output logic      [1:0]        res_sum_len
);

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   logic [31:0]   reg_ctrl;
   logic [31:0]   reg_pos;
   logic [31:0]   reg_prot1;
   logic [31:0]   reg_sumpos;
   logic [63:0]   second_protocol_match_value;
   logic [63:0]   second_protocol_match_mask;
   logic [127:0]  flow_compare_value;
   logic [127:0]  flow_compare_mask;
   logic [7:0]    match_count;

   wire [1:0] comparator_protocol_select = reg_ctrl[CTRL_MODE_LSB +: 2];
   wire [2:0] following_stage_select     = reg_ctrl[CTRL_SEL_LSB +: 3];
   wire       udp_sum_zero_enable        = reg_ctrl[CTRL_ZERO_BIT];
   wire       udp_sum_fixup_enable       = reg_ctrl[CTRL_FIX_BIT];
   wire [1:0] udp_sum_length             = reg_ctrl[CTRL_SLEN_LSB +: 2];
   wire [4:0] first_protocol_match_position  = reg_pos[POS_P1_LSB +: 5];
   wire [6:0] second_protocol_match_position = reg_pos[POS_P2_LSB +: 7];
   wire [4:0] flow_field_position            = reg_pos[POS_FL_LSB +: 5];
   wire [7:0] header_length_bytes            = reg_pos[POS_HL_LSB +: 8];
   wire [7:0] first_protocol_match_value = reg_prot1[7:0];
   wire [7:0] first_protocol_match_mask  = reg_prot1[PROT1_MASK_LSB +: 8];
   wire [7:0] udp_sum_position           = reg_sumpos[7:0];

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire hit_ctrl   = paddr == ADDR_CTRL;
   wire hit_pos    = paddr == ADDR_POS;
   wire hit_prot1  = paddr == ADDR_PROT1;
   wire hit_sumpos = paddr == ADDR_SUMPOS;
   wire hit_m2l    = paddr == ADDR_MATCH2_L;
   wire hit_m2h    = paddr == ADDR_MATCH2_H;
   wire hit_k2l    = paddr == ADDR_MASK2_L;
   wire hit_k2h    = paddr == ADDR_MASK2_H;
   wire hit_fval   = (paddr[7:4] == ADDR_FLOWVAL[7:4]) && (paddr[1:0] == 2'h0);
   wire hit_fmask  = (paddr[7:4] == ADDR_FLOWMASK[7:4]) && (paddr[1:0] == 2'h0);
   wire hit_status = paddr == ADDR_STATUS;
   wire [1:0] flow_word = paddr[3:2];

   wire addr_hit = hit_ctrl | hit_pos | hit_prot1 | hit_sumpos | hit_m2l | hit_m2h
                 | hit_k2l | hit_k2h | hit_fval | hit_fmask | hit_status;

   wire apb_access = psel && penable && !pready;
   wire apb_write  = psel && penable && pready && pwrite && addr_hit && ce;

   // ----------------------------------------
   // status observed by software
   // ----------------------------------------
   logic       last_short;
   logic [5:0] last_checks;

   wire [31:0] status_word = {16'h0, match_count, 1'b0, last_short, last_checks};

   wire [31:0] rd_mux =
        hit_ctrl   ? reg_ctrl :
        hit_pos    ? reg_pos :
        hit_prot1  ? reg_prot1 :
        hit_sumpos ? reg_sumpos :
        hit_m2l    ? second_protocol_match_value[31:0] :
        hit_m2h    ? second_protocol_match_value[63:32] :
        hit_k2l    ? second_protocol_match_mask[31:0] :
        hit_k2h    ? second_protocol_match_mask[63:32] :
        hit_fval   ? flow_compare_value[32*flow_word +: 32] :
        hit_fmask  ? flow_compare_mask[32*flow_word +: 32] :
        hit_status ? status_word : 32'h0000_0000;

   // ----------------------------------------
   // apb answer: one wait state
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= apb_access;
         pslverr <= apb_access && !addr_hit;
         if (apb_access) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_ctrl   <= CTRL_RST;
         reg_pos    <= WORD_RST;
         reg_prot1  <= WORD_RST;
         reg_sumpos <= WORD_RST;
      end else if (apb_write) begin
         if (hit_ctrl)   reg_ctrl   <= pwdata & CTRL_WMASK;
         if (hit_pos)    reg_pos    <= pwdata & POS_WMASK;
         if (hit_prot1)  reg_prot1  <= pwdata & PROT1_WMASK;
         if (hit_sumpos) reg_sumpos <= pwdata & SUMPOS_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_protocol_match_value <= '0;
         second_protocol_match_mask  <= '0;
         flow_compare_value          <= '0;
         flow_compare_mask           <= '0;
      end else if (apb_write) begin
         if (hit_m2l)   second_protocol_match_value[31:0]  <= pwdata;
         if (hit_m2h)   second_protocol_match_value[63:32] <= pwdata;
         if (hit_k2l)   second_protocol_match_mask[31:0]   <= pwdata;
         if (hit_k2h)   second_protocol_match_mask[63:32]  <= pwdata;
         if (hit_fval)  flow_compare_value[32*flow_word +: 32] <= pwdata;
         if (hit_fmask) flow_compare_mask[32*flow_word +: 32]  <= pwdata;
      end
   end

   // ----------------------------------------
   // byte collection
   // ----------------------------------------
   ipacmp_state_t state;
   ipacmp_state_t next_state;
   logic [7:0]    byte_idx;
   logic [3:0]    ver_nibble;
   logic [7:0]    flags_byte;
   logic [7:0]    frag_byte;
   logic          short_hdr;

   wire is_v4    = comparator_protocol_select == MODE_IPV4;
   wire is_v6    = comparator_protocol_select == MODE_IPV6;
   wire is_short = comparator_protocol_select == MODE_IPV4
                || comparator_protocol_select == MODE_OTHER32;

   // 32-bit flow for IPv4 and other-32, else the 128-bit address
   wire [4:0] flow_span = is_short ? FLOW_SPAN_SHORT : FLOW_SPAN_LONG;

   wire       take    = hdr_valid && ((state == ST_IDLE && hdr_start)
                                   || state == ST_COLLECT);
   wire [7:0] idx_now = (state == ST_IDLE) ? 8'h00 : byte_idx;

   // last byte any check needs
   wire [7:0] need_a  = (is_v4 || is_v6) ? IPV4_MIN_BYTES : OTHER_MIN_BYTES;
   wire [7:0] need_b  = {3'h0, first_protocol_match_position} + 8'h01;
   wire [7:0] need_c  = {1'b0, second_protocol_match_position} + PROT2_BYTES;
   wire [7:0] need_d  = {3'h0, flow_field_position} + {3'h0, flow_span};
   wire [7:0] need_ab = (need_a > need_b) ? need_a : need_b;
   wire [7:0] need_cd = (need_c > need_d) ? need_c : need_d;
   wire [7:0] need    = (need_ab > need_cd) ? need_ab : need_cd;
   wire       last    = take && (idx_now == need - 8'h01);
   wire       cut     = hdr_end && !last && (state == ST_COLLECT);

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE:    if (take) next_state = last ? ST_DONE : ST_COLLECT;
         ST_COLLECT: if (last || cut) next_state = ST_DONE;
         ST_DONE:    next_state = ST_IDLE;
         default:    next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= ST_IDLE;
         byte_idx  <= 8'h00;
         short_hdr <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         if (take) byte_idx <= idx_now + 8'h01;
         if (state == ST_IDLE) short_hdr <= 1'b0;
         else if (cut) short_hdr <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ver_nibble <= 4'h0;
         flags_byte <= 8'h00;
         frag_byte  <= 8'h00;
      end else if (ce && take) begin
         if (idx_now == 8'h00)           ver_nibble <= hdr_byte[7:4];
         if (idx_now == IPV4_FLAGS_BYTE) flags_byte <= hdr_byte;
         if (idx_now == IPV4_FRAG_BYTE)  frag_byte  <= hdr_byte;
      end
   end

   // ----------------------------------------
   // field windows
   // ----------------------------------------
   logic [7:0]   p1_field;
   logic [63:0]  p2_field;
   logic [127:0] fl_field;

   ipacmp_window #(.NBYTES(1), .POS_W(5)) u_prot1 (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .valid   (take),
      .idx     (idx_now),
      .data    (hdr_byte),
      .pos     (first_protocol_match_position),
      .span    (5'h01),
      .field   (p1_field)
   );

   ipacmp_window #(.NBYTES(8), .POS_W(7)) u_prot2 (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .valid   (take),
      .idx     (idx_now),
      .data    (hdr_byte),
      .pos     (second_protocol_match_position),
      .span    (PROT2_BYTES[4:0]),
      .field   (p2_field)
   );

   ipacmp_window #(.NBYTES(16), .POS_W(5)) u_flow (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .valid   (take),
      .idx     (idx_now),
      .data    (hdr_byte),
      .pos     (flow_field_position),
      .span    (flow_span),
      .field   (fl_field)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   wire ver_ok  = is_v4 ? (ver_nibble == VER_IPV4) :
                  is_v6 ? (ver_nibble == VER_IPV6) : 1'b1;
   wire frag_ok = !is_v4 || (!flags_byte[IPV4_MF_BIT]
                  && flags_byte[4:0] == 5'h00 && frag_byte == 8'h00);
   wire p1_ok   = masked_ok({120'h0, first_protocol_match_value},
                            {120'h0, first_protocol_match_mask},
                            {120'h0, p1_field});
   wire p2_ok   = masked_ok({64'h0, second_protocol_match_value},
                            {64'h0, second_protocol_match_mask},
                            {64'h0, p2_field});
   wire flow_ok = is_short ?
                  masked_ok({96'h0, flow_compare_value[127:96]},
                            {96'h0, flow_compare_mask[127:96]},
                            {96'h0, fl_field[31:0]}) :
                  masked_ok(flow_compare_value, flow_compare_mask, fl_field);
   wire sel_ok  = following_stage_select == SEL_ETH2
               || following_stage_select == SEL_IP1
               || following_stage_select == SEL_IP2
               || following_stage_select == SEL_PTP;
   wire all_ok  = !short_hdr && ver_ok && frag_ok && p1_ok && p2_ok && sel_ok;
   wire done    = state == ST_DONE;

   // ----------------------------------------
   // result outputs
   // ----------------------------------------
   wire [OFS_W-1:0] next_ofs = OFS_W'(hdr_base + header_length_bytes);
   wire [OFS_W-1:0] sum_ofs  = OFS_W'(hdr_base + udp_sum_position);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_valid       <= 1'b0;
         res_match       <= 1'b0;
         res_flow_hit    <= 1'b0;
         res_next_sel    <= 3'h0;
         res_next_offset <= '0;
         res_sum_zero    <= 1'b0;
         res_sum_fixup   <= 1'b0;
         res_sum_pos     <= '0;
         res_sum_len     <= 2'h0;
      end else if (ce) begin
         res_valid <= done;
         if (done) begin
            res_match       <= all_ok;
            res_flow_hit    <= all_ok && flow_ok;
            res_next_sel    <= all_ok ? following_stage_select : 3'h0;
            res_next_offset <= next_ofs;
            res_sum_zero    <= all_ok && udp_sum_zero_enable
                               && is_v4 && ingress;
            res_sum_fixup   <= all_ok && udp_sum_fixup_enable;
            res_sum_pos     <= is_v4 ? sum_ofs : '0;
            res_sum_len     <= udp_sum_length;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_count <= 8'h00;
         last_short  <= 1'b0;
         last_checks <= 6'h00;
      end else if (ce && done) begin
         if (all_ok) match_count <= match_count + 8'h01;
         last_short  <= short_hdr;
         last_checks <= {flow_ok, sel_ok, p2_ok, p1_ok, frag_ok, ver_ok};
      end
   end

endmodule // ipacmp_stage
`default_nettype wire

// ---- rtl/ipacmp_pkg.sv ----
`default_nettype none
package ipacmp_pkg;

   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_POS      = 8'h04;
   localparam logic [7:0] ADDR_PROT1    = 8'h08;
   localparam logic [7:0] ADDR_SUMPOS   = 8'h0c;
   localparam logic [7:0] ADDR_MATCH2_L = 8'h10;
   localparam logic [7:0] ADDR_MATCH2_H = 8'h14;
   localparam logic [7:0] ADDR_MASK2_L  = 8'h18;
   localparam logic [7:0] ADDR_MASK2_H  = 8'h1c;
   localparam logic [7:0] ADDR_FLOWVAL  = 8'h20;
   localparam logic [7:0] ADDR_FLOWMASK = 8'h30;
   localparam logic [7:0] ADDR_STATUS   = 8'h40;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_SEL_LSB   = 2;
   localparam int CTRL_ZERO_BIT  = 5;
   localparam int CTRL_FIX_BIT   = 6;
   localparam int CTRL_SLEN_LSB  = 8;
   localparam int POS_P1_LSB     = 0;
   localparam int POS_P2_LSB     = 8;
   localparam int POS_FL_LSB     = 16;
   localparam int POS_HL_LSB     = 24;
   localparam int PROT1_MASK_LSB = 8;
   localparam int IPV4_MF_BIT    = 5;

   // ----------------------------------------
   // reset values and write masks
   // ----------------------------------------
   localparam logic [31:0] CTRL_RST     = 32'h0000_0200;
   localparam logic [31:0] WORD_RST     = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK   = 32'h0000_037f;
   localparam logic [31:0] POS_WMASK    = 32'hff1f_7f1f;
   localparam logic [31:0] PROT1_WMASK  = 32'h0000_ffff;
   localparam logic [31:0] SUMPOS_WMASK = 32'h0000_00ff;

   // ----------------------------------------
   // protocol constants
   // ----------------------------------------
   localparam logic [1:0] MODE_IPV4    = 2'h0;
   localparam logic [1:0] MODE_IPV6    = 2'h1;
   localparam logic [1:0] MODE_OTHER32 = 2'h2;
   localparam logic [1:0] MODE_OTHER128 = 2'h3;
   localparam logic [3:0] VER_IPV4     = 4'h4;
   localparam logic [3:0] VER_IPV6     = 4'h6;
   localparam logic [2:0] SEL_ETH2     = 3'h1;
   localparam logic [2:0] SEL_IP1      = 3'h2;
   localparam logic [2:0] SEL_IP2      = 3'h3;
   localparam logic [2:0] SEL_PTP      = 3'h5;
   localparam logic [7:0] IPV4_FLAGS_BYTE = 8'h06;
   localparam logic [7:0] IPV4_FRAG_BYTE  = 8'h07;
   localparam logic [7:0] IPV4_MIN_BYTES  = 8'h08;
   localparam logic [7:0] OTHER_MIN_BYTES = 8'h01;
   localparam logic [7:0] PROT2_BYTES     = 8'h08;
   localparam logic [4:0] FLOW_SPAN_SHORT = 5'h04;
   localparam logic [4:0] FLOW_SPAN_LONG  = 5'h10;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_COLLECT = 2'b01,
      ST_DONE    = 2'b11
   } ipacmp_state_t;

   // masked compare: clear mask bits never mismatch
   function automatic logic masked_ok(input logic [127:0] value,
                                      input logic [127:0] mask,
                                      input logic [127:0] field);
      masked_ok = ((value ^ field) & mask) == 128'h0;
   endfunction

endpackage
`default_nettype wire

// ---- rtl/ipacmp_window.sv ----
`default_nettype none
module ipacmp_window import ipacmp_pkg::*; #(
   parameter int NBYTES = 8,
   parameter int POS_W  = 7
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  ce,
   // byte stream
   input  wire logic                  valid,
   input  wire logic [7:0]            idx,
   input  wire logic [7:0]            data,
   // window placement
   input  wire logic [POS_W-1:0]      pos,
   input  wire logic [4:0]            span,
   // captured field, first byte most significant
   output logic      [8*NBYTES-1:0]   field
);

   wire [8:0] rel     = {1'b0, idx} - {{(9-POS_W){1'b0}}, pos};
   wire       in_win  = ~rel[8] && (rel[7:0] < {3'h0, span});
   wire       shift   = ce && valid && in_win;

   generate
      if (NBYTES == 1) begin : g_one
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) field <= '0;
            else if (shift) field <= data;
         end
      end else begin : g_many
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) field <= '0;
            else if (shift) field <= {field[8*NBYTES-9:0], data};
         end
      end
   endgenerate

endmodule // ipacmp_window
`default_nettype wire

// ---- tb/ipacmp_stage_props.sv ----
`default_nettype none
module ipacmp_stage_props (
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       ce,
   // apb
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   // stream and result
   input wire logic       hdr_start,
   input wire logic       hdr_valid,
   input wire logic       ingress,
   input wire logic       res_valid,
   input wire logic       res_match,
   input wire logic       res_flow_hit,
   input wire logic [2:0] res_next_sel,
   input wire logic       res_sum_zero,
   input wire logic       res_sum_fixup
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------
   // apb answer
   // ----------------
   property p_rdy; $rose(penable) && psel && ce |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready late");
   property p_rdy1; pready && ce |=> !pready; endproperty
   a_rdy1: assert property (p_rdy1) else $error("pready long");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("pslverr alone");
   // ----------------
   // result
   // ----------------
   property p_ans; hdr_start && hdr_valid |-> ##[2:200] res_valid; endproperty
   a_ans: assert property (p_ans) else $error("no result");
   property p_v1; res_valid |=> !res_valid; endproperty
   a_v1: assert property (p_v1) else $error("res_valid long");
   property p_hold; !res_valid |-> $stable(res_match) && $stable(res_next_sel); endproperty
   a_hold: assert property (p_hold) else $error("result moved");
   property p_sel; res_valid && res_match |-> res_next_sel inside {1, 2, 3, 5}; endproperty
   a_sel: assert property (p_sel) else $error("reserved sel");
   property p_sel0; res_valid && !res_match |-> res_next_sel == 3'h0; endproperty
   a_sel0: assert property (p_sel0) else $error("sel without match");
   property p_gate; res_sum_zero || res_sum_fixup || res_flow_hit |-> res_match; endproperty
   a_gate: assert property (p_gate) else $error("action without match");
   property p_ing; res_valid && res_sum_zero |-> $past(ingress); endproperty
   a_ing: assert property (p_ing) else $error("zero on egress");
endmodule // ipacmp_stage_props
`default_nettype wire

// ---- tb/ipacmp_hdr_src.sv ----
`default_nettype none
module ipacmp_hdr_src (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // bench control
   input  wire logic         go,
   input  wire logic         stall,
   input  wire logic [7:0]   len,
   input  wire logic [223:0] frame,
   // byte stream
   output logic              hdr_start,
   output logic              hdr_valid,
   output logic              hdr_end,
   output logic      [7:0]   hdr_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       busy;
   logic [7:0] idx;
   // ----------------
   // sender, idle byte toggles
   // ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {busy, idx, hdr_start, hdr_valid, hdr_end, hdr_byte} <= '0;
      end else if (busy && !stall) begin
         hdr_start <= idx == 8'h00;
         hdr_valid <= 1'b1;
         hdr_end   <= idx == len - 8'h01 && len < 8'h1c;
         hdr_byte  <= frame[223 - 8 * idx -: 8];
         idx       <= idx + 8'h01;
         busy      <= idx != len - 8'h01;
      end else begin
         busy      <= busy | go;
         idx       <= busy ? idx : 8'h00;
         hdr_start <= 1'b0;
         hdr_valid <= 1'b0;
         hdr_end   <= 1'b0;
         hdr_byte  <= ~hdr_byte;
      end
   end
endmodule // ipacmp_hdr_src
`default_nettype wire

// ---- tb/tb_ipacmp_stage.sv ----
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
   $display("mismatch %s exp %h seen %h", nm, e, s); end end
module tb_ipacmp_stage;
   timeunit 1ns;
   timeprecision 1ns;
   import ipacmp_pkg::*;
   localparam logic [63:0] M2V = 64'h0123_4567_89ab_cdef;
   localparam logic [63:0] M2K = 64'hffff_0000_ff00_00ff;
   localparam logic [31:0] FV  = 32'hc0a8_0a01;
   logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic         go = 0, stall = 0, ingress = 0, err;
   logic [7:0]   paddr = 0, len = 0, hdr_base = 0, hdr_byte, res_next_offset, res_sum_pos;
   logic [31:0]  pwdata = 0, prdata, rd;
   logic [223:0] frame = 0;
   logic         pready, pslverr, hdr_start, hdr_valid, hdr_end, res_valid, res_match;
   logic         res_flow_hit, res_sum_zero, res_sum_fixup;
   logic [2:0]   res_next_sel;
   logic [1:0]   res_sum_len;
   int           mismatches = 0, cmp_count = 0;

   ipacmp_stage dut_u (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .hdr_start, .hdr_valid, .hdr_byte, .hdr_end, .hdr_base,
      .ingress, .res_valid, .res_match, .res_flow_hit, .res_next_sel, .res_next_offset,
      .res_sum_zero, .res_sum_fixup, .res_sum_pos, .res_sum_len);
   ipacmp_hdr_src src_u (.pclk, .presetn, .go, .stall, .len, .frame, .hdr_start, .hdr_valid,
      .hdr_end, .hdr_byte);

   initial begin
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) stall <= ($urandom & 32'h3) == 32'h0;

   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic wait_for(ref logic s);
      int n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (s !== 1'b1 && n < 200);
      if (s !== 1'b1) begin
         mismatches++;
         final_report();
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      wait_for(pready);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   task automatic send(input logic [7:0] n, input logic [223:0] f);
      @(posedge pclk);
      {len, frame, go} <= {n, f, 1'b1};
      @(posedge pclk);
      go <= 1'b0;
      wait_for(res_valid);
   endtask

   function automatic logic exp_match(input logic [223:0] f, input logic [1:0] md,
                                      input logic [2:0] sl, input logic [7:0] k1);
      exp_match = (md > 2'h1 || f[223:220] == (md == 2'h0 ? VER_IPV4 : VER_IPV6))
                  && (md != 2'h0 || f[173:160] == 14'h0)
                  && ((f[151:144] ^ 8'h11) & k1) == 8'h0
                  && ((f[63:0] ^ M2V) & M2K) == 64'h0
                  && sl inside {SEL_ETH2, SEL_IP1, SEL_IP2, SEL_PTP};
   endfunction

   initial begin
      logic [223:0] f;
      logic [31:0]  r;
      logic [1:0]   md;
      logic [2:0]   sl;
      logic [7:0]   k1;
      logic         ok, ze, fx;
      r = $urandom(98183);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0);
      `CHK("ctrl reset", CTRL_RST, rd)
      apb(1'b0, 8'h44, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      apb(1'b1, ADDR_POS, 32'hffff_ffff);
      apb(1'b0, ADDR_POS, 32'h0);
      `CHK("pos width", POS_WMASK, rd)
      apb(1'b1, ADDR_POS, 32'h140c_1409);
      apb(1'b1, ADDR_SUMPOS, 32'h0000_001a);
      apb(1'b1, ADDR_MATCH2_L, M2V[31:0]);
      apb(1'b1, ADDR_MATCH2_H, M2V[63:32]);
      apb(1'b1, ADDR_MASK2_L, M2K[31:0]);
      apb(1'b1, ADDR_MASK2_H, M2K[63:32]);
      apb(1'b1, ADDR_FLOWVAL + 8'h0c, FV);
      apb(1'b1, ADDR_FLOWMASK + 8'h0c, 32'hffff_ffff);
      for (int i = 0; i < 64; i++) begin
         f = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
         r = $urandom;
         f[223:220] = r[0] ? VER_IPV4 : VER_IPV6;
         if (r[1]) f[173:160] = 14'h0;
         if (r[2]) f[151:144] = 8'h11;
         if (r[3] | r[4]) f[63:0] = M2V ^ ({$urandom, $urandom} & ~M2K);
         if (r[5]) f[127:96] = FV;
         md = r[7:6];
         sl = (i < 8) ? i[2:0] : (r[12] ? SEL_PTP : r[10:8]);
         k1 = r[11] ? 8'hff : 8'h00;
         fx = r[14];
         ze = r[13] & !fx;
         apb(1'b1, ADDR_CTRL, {22'h0, r[25:24], 1'b0, fx, ze, sl, md});
         apb(1'b1, ADDR_PROT1, {16'h0, k1, 8'h11});
         {ingress, hdr_base} <= r[23:15];
         send(i == 8 ? 8'h14 : 8'h1c, f);
         ok = exp_match(f, md, sl, k1) && i != 8;
         `CHK("match", ok, res_match)
         `CHK("next sel", ok ? sl : 3'h0, res_next_sel)
         `CHK("next offset", hdr_base + 8'h14, res_next_offset)
         `CHK("sum zero", ze && md == 2'h0 && ingress && ok, res_sum_zero)
         `CHK("sum fixup", fx && ok, res_sum_fixup)
         `CHK("sum pos", md == 2'h0 ? hdr_base + 8'h1a : 8'h00, res_sum_pos)
         `CHK("sum len", r[25:24], res_sum_len)
         `CHK("flow hit", ok && f[127:96] == FV, res_flow_hit)
         $display("test %0d done", i);
      end
      final_report();
   end
endmodule // tb_ipacmp_stage
bind ipacmp_stage ipacmp_stage_props u_props (.pclk, .presetn, .ce, .psel, .penable, .pready,
   .pslverr, .hdr_start, .hdr_valid, .ingress, .res_valid, .res_match, .res_flow_hit,
   .res_next_sel, .res_sum_zero, .res_sum_fixup);
`default_nettype wire
